// ===== core/pll_serial_config_port.sv
// Serial configuration port: shift register, addressed load, readback and field decode.
// What this block does
// (R1) A 32-bit shift register fills from serial data under clock, data and strobe.
// (R2) Words arrive bit 0 first; each bit is sampled at a serial clock rise.
// (R3) A strobe rise, asynchronous to the clock, copies the word to its register.
// (R4) The low five word bits address the register that the strobe loads.
// (R5) A separate readback pin shifts out the contents of a chosen register.
// (R6) First register bits 5 to 17 hold the reference divider, 1 to 8191.
// (R7) First register bit 19 set makes the phase detector use the falling edge.
// (R8) First register bit 20 set selects negative tuning slope; default one.
// (R9) Bits 21 to 25 give pump current code, 00000 maximum; default 01010.
// (R10) Bit 26 set doubles the charge pump current chosen by the code.
// (R11) Bits 27 to 30 scale calibration clock: 1000 and 0111 unity, above 1000 divide, below 0111 multiply.
// (R12) Second register bits 5 to 20 hold the feedback divider; default bit 12.
// (R13) Second register bits 21 and 22 pick the pre-prescaler division ratio.
// (R14) Pre-prescaler code 00 divides by 1, 01 by 2, 10 by 4.
// (R15) Bit 23 picks dual modulus: zero 4/5, one 8/9; default one.
// (R16) Bits 26 and 27 pick one of four oscillator cores, 00 lowest.
// (R17) Bit 28 set enables single-core calibration instead of all cores.
// (R18) In single-core mode calibration runs only on the selected core.
// (R19) Bits 29 and 30 set the error count accepted during calibration.
// (R20) Writing one to bit 31 starts calibration; the bit clears itself afterwards.
// (R21) Host shifts 32 bits with strobe low, then raises strobe once.
// (R22) Host writes zero to all reserved bits of both registers.
`timescale 1ns/1ns
module pll_serial_config_port (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_ser_clk,
  input  wire logic        i_ser_data,
  input  wire logic        i_load_strobe,
  input  wire logic        i_cal_done,
  output logic             o_readback_out,
  output logic [12:0]      o_ref_divider,
  output logic             o_ref_edge_select,
  output logic             o_osc_slope_negative,
  output logic [4:0]       o_pump_current_code,
  output logic             o_pump_current_x2,
  output logic [3:0]       o_cal_clk_scale,
  output logic [2:0]       o_cal_clk_div_shift,
  output logic [2:0]       o_cal_clk_mul_shift,
  output logic [15:0]      o_feedback_int_divider,
  output logic [2:0]       o_pre_div_ratio,
  output logic             o_dual_modulus_select,
  output logic [1:0]       o_osc_core_select,
  output logic             o_single_core_tune,
  output logic [3:0]       o_cal_core_mask,
  output logic [1:0]       o_tune_error_count,
  output logic             o_cal_start,
  output logic             o_cal_pending
);
  localparam int unsigned PIN_COUNT = 3;
  localparam int unsigned PIN_CLK   = 0;
  localparam int unsigned PIN_DATA  = 1;
  localparam int unsigned PIN_LOAD  = 2;

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;

  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic [31:0] ref_pump_r;
  logic [31:0] ref_pump_nxt;
  logic [31:0] fb_tune_r;
  logic [31:0] fb_tune_nxt;
  logic [31:0] rb_shift_r;
  logic [31:0] rb_shift_nxt;
  logic        cal_start_r;
  logic        cal_start_nxt;

  logic [4:0]  word_addr;
  logic [1:0]  rb_sel;
  logic        load_ref;
  logic        load_fb;
  logic        load_rb;

  localparam int unsigned CAL_SCALE_LSB_I = pll_cfg_pkg::CAL_SCALE_LSB;

  // Extracts the calibration clock scale field from a word.
  function automatic logic [3:0] cal_scale_of(input logic [31:0] w);
    cal_scale_of = w[CAL_SCALE_LSB_I +: pll_cfg_pkg::CAL_SCALE_W];
  endfunction

  assign pin_raw[PIN_CLK]  = i_ser_clk;
  assign pin_raw[PIN_DATA] = i_ser_data;
  assign pin_raw[PIN_LOAD] = i_load_strobe;

  // Every pin is brought into the system clock domain through two flops.
  generate
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
      pin_sync_edge u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_pin     (pin_raw[g]),
        .o_level   (pin_level[g]),
        .o_rise    (pin_rise[g]),
        .o_fall    (pin_fall[g])
      );
    end
  endgenerate

  assign word_addr = shift_r[pll_cfg_pkg::ADDR_W-1:0];                               // [R4]
  assign rb_sel    = shift_r[pll_cfg_pkg::RB_SEL_LSB +: pll_cfg_pkg::RB_SEL_W];
  assign load_ref  = pin_rise[PIN_LOAD] && (word_addr == pll_cfg_pkg::ADDR_REF_PUMP); // [R3] [R4]
  assign load_fb   = pin_rise[PIN_LOAD] && (word_addr == pll_cfg_pkg::ADDR_FB_TUNE);  // [R3] [R4]
  assign load_rb   = pin_rise[PIN_LOAD] && (word_addr == pll_cfg_pkg::ADDR_READBACK);

  // Serial shift register; the strobe level gates nothing so stray edges still shift.
  always_comb begin
    shift_nxt = shift_r;
    if (pin_rise[PIN_CLK]) begin
      shift_nxt = {pin_level[PIN_DATA], shift_r[31:1]};                               // [R1] [R2]
    end
  end

  // Configuration registers loaded by address on the strobe rise.
  always_comb begin
    ref_pump_nxt  = ref_pump_r;
    fb_tune_nxt   = fb_tune_r;
    cal_start_nxt = 1'b0;
    if (load_ref) begin
      ref_pump_nxt = shift_r;                                                          // [R3]
    end
    if (i_cal_done) begin
      fb_tune_nxt[pll_cfg_pkg::CAL_START_BIT] = 1'b0;                                  // [R20]
    end
    if (load_fb) begin
      fb_tune_nxt   = shift_r;                                                         // [R3]
      cal_start_nxt = shift_r[pll_cfg_pkg::CAL_START_BIT];                             // [R20]
    end
  end

  // Readback shifter: loaded by a request word, shifted on serial clock falls.
  always_comb begin
    rb_shift_nxt = rb_shift_r;
    if (load_rb) begin
      unique case (rb_sel)
        pll_cfg_pkg::RB_SEL_REF: rb_shift_nxt = ref_pump_r;                            // [R5]
        pll_cfg_pkg::RB_SEL_FB:  rb_shift_nxt = fb_tune_r;                             // [R5]
        default:                 rb_shift_nxt = '0;
      endcase
    end else if (pin_fall[PIN_CLK]) begin
      rb_shift_nxt = {1'b0, rb_shift_r[31:1]};                                         // [R5]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      shift_r     <= '0;
      ref_pump_r  <= pll_cfg_pkg::RST_REF_PUMP;                                        // [R8] [R9]
      fb_tune_r   <= pll_cfg_pkg::RST_FB_TUNE;                                         // [R12] [R15]
      rb_shift_r  <= '0;
      cal_start_r <= 1'b0;
    end else begin
      shift_r     <= shift_nxt;
      ref_pump_r  <= ref_pump_nxt;
      fb_tune_r   <= fb_tune_nxt;
      rb_shift_r  <= rb_shift_nxt;
      cal_start_r <= cal_start_nxt;
    end
  end

  assign o_readback_out = rb_shift_r[0];                                               // [R5]

  // Reference and pump field decode.
  assign o_ref_divider        = ref_pump_r[pll_cfg_pkg::REF_DIV_LSB +: pll_cfg_pkg::REF_DIV_W];     // [R6]
  assign o_ref_edge_select    = ref_pump_r[pll_cfg_pkg::REF_EDGE_BIT];                               // [R7]
  assign o_osc_slope_negative = ref_pump_r[pll_cfg_pkg::SLOPE_NEG_BIT];                              // [R8]
  assign o_pump_current_code  = ref_pump_r[pll_cfg_pkg::PUMP_CODE_LSB +: pll_cfg_pkg::PUMP_CODE_W]; // [R9]
  assign o_pump_current_x2    = ref_pump_r[pll_cfg_pkg::PUMP_X2_BIT];                                // [R10]
  assign o_cal_clk_scale      = cal_scale_of(ref_pump_r);                                            // [R11]

  // Calibration clock scale as a power-of-two divide or multiply; code 0111 acts as unity.
  always_comb begin
    o_cal_clk_div_shift = '0;
    o_cal_clk_mul_shift = '0;
    if (o_cal_clk_scale >= pll_cfg_pkg::CAL_SCALE_UNITY) begin
      o_cal_clk_div_shift = 3'(o_cal_clk_scale - pll_cfg_pkg::CAL_SCALE_UNITY);                      // [R11]
    end else if (o_cal_clk_scale <= pll_cfg_pkg::CAL_SCALE_MUL2) begin
      o_cal_clk_mul_shift = 3'(pll_cfg_pkg::CAL_MUL_BASE - o_cal_clk_scale[2:0]);                    // [R11]
    end
  end

  // Feedback and tuning field decode.
  assign o_feedback_int_divider = fb_tune_r[pll_cfg_pkg::FB_DIV_LSB +: pll_cfg_pkg::FB_DIV_W];       // [R12]
  assign o_dual_modulus_select  = fb_tune_r[pll_cfg_pkg::MODULUS_BIT];                               // [R15]
  assign o_osc_core_select      = fb_tune_r[pll_cfg_pkg::CORE_SEL_LSB +: pll_cfg_pkg::CORE_SEL_W];   // [R16]
  assign o_single_core_tune     = fb_tune_r[pll_cfg_pkg::SINGLE_CORE_BIT];                           // [R17]
  assign o_tune_error_count     = fb_tune_r[pll_cfg_pkg::ERR_CNT_LSB +: pll_cfg_pkg::ERR_CNT_W];     // [R19]
  assign o_cal_pending          = fb_tune_r[pll_cfg_pkg::CAL_START_BIT];                             // [R20]
  assign o_cal_start            = cal_start_r;                                                       // [R20]

  // Pre-prescaler ratio; the unused code 11 falls back to divide by one.
  always_comb begin
    unique case (fb_tune_r[pll_cfg_pkg::PRE_DIV_LSB +: pll_cfg_pkg::PRE_DIV_W])                      // [R13]
      pll_cfg_pkg::PRE_DIV_1: o_pre_div_ratio = pll_cfg_pkg::RATIO_1;                                // [R14]
      pll_cfg_pkg::PRE_DIV_2: o_pre_div_ratio = pll_cfg_pkg::RATIO_2;                                // [R14]
      pll_cfg_pkg::PRE_DIV_4: o_pre_div_ratio = pll_cfg_pkg::RATIO_4;                                // [R14]
      default:                o_pre_div_ratio = pll_cfg_pkg::RATIO_1;
    endcase
  end

  // Cores swept by calibration: all of them, or only the selected one.
  always_comb begin
    if (o_single_core_tune) begin
      o_cal_core_mask = pll_cfg_pkg::CORE_ONE << o_osc_core_select;                                  // [R18]
    end else begin
      o_cal_core_mask = pll_cfg_pkg::CORES_ALL;                                                      // [R17]
    end
  end
endmodule // pll_serial_config_port

// ===== common/pll_cfg_pkg.sv
// Constants shared by the serial configuration port of the synthesizer.
package pll_cfg_pkg;
  localparam int unsigned WORD_W         = 32;
  localparam int unsigned ADDR_W         = 5;
  localparam int unsigned CLK_SYS_NS     = 10;
  localparam int unsigned SYNC_STAGES    = 2;

  // Register addresses carried in the low five bits of each word.
  localparam logic [4:0]  ADDR_READBACK  = 5'h00;
  localparam logic [4:0]  ADDR_REF_PUMP  = 5'h09;
  localparam logic [4:0]  ADDR_FB_TUNE   = 5'h0a;

  // Reset values of the two configuration registers.
  localparam logic [31:0] RST_REF_PUMP   = 32'h41500029;
  localparam logic [31:0] RST_FB_TUNE    = 32'h08a0100a;

  // Readback request: register choice field.
  localparam int unsigned RB_SEL_LSB     = 5;
  localparam int unsigned RB_SEL_W       = 2;
  localparam logic [1:0]  RB_SEL_REF     = 2'h1;
  localparam logic [1:0]  RB_SEL_FB      = 2'h2;

  // Field layout of the reference and pump register.
  localparam int unsigned REF_DIV_LSB    = 5;
  localparam int unsigned REF_DIV_W      = 13;
  localparam int unsigned REF_EDGE_BIT   = 19;
  localparam int unsigned SLOPE_NEG_BIT  = 20;
  localparam int unsigned PUMP_CODE_LSB  = 21;
  localparam int unsigned PUMP_CODE_W    = 5;
  localparam int unsigned PUMP_X2_BIT    = 26;
  localparam int unsigned CAL_SCALE_LSB  = 27;
  localparam int unsigned CAL_SCALE_W    = 4;

  // Calibration clock scale codes.
  localparam logic [3:0]  CAL_SCALE_UNITY = 4'h8;
  localparam logic [3:0]  CAL_SCALE_MUL2  = 4'h6;
  localparam logic [2:0]  CAL_MUL_BASE    = 3'h7;

  // Field layout of the feedback and tuning register.
  localparam int unsigned FB_DIV_LSB     = 5;
  localparam int unsigned FB_DIV_W       = 16;
  localparam int unsigned PRE_DIV_LSB    = 21;
  localparam int unsigned PRE_DIV_W      = 2;
  localparam int unsigned MODULUS_BIT    = 23;
  localparam int unsigned CORE_SEL_LSB   = 26;
  localparam int unsigned CORE_SEL_W     = 2;
  localparam int unsigned SINGLE_CORE_BIT = 28;
  localparam int unsigned ERR_CNT_LSB    = 29;
  localparam int unsigned ERR_CNT_W      = 2;
  localparam int unsigned CAL_START_BIT  = 31;

  // Pre-prescaler divider codes and the ratios they give.
  localparam logic [1:0]  PRE_DIV_1      = 2'h0;
  localparam logic [1:0]  PRE_DIV_2      = 2'h1;
  localparam logic [1:0]  PRE_DIV_4      = 2'h2;
  localparam logic [2:0]  RATIO_1        = 3'h1;
  localparam logic [2:0]  RATIO_2        = 3'h2;
  localparam logic [2:0]  RATIO_4        = 3'h4;

  localparam int unsigned CORE_COUNT     = 4;
  localparam logic [3:0]  CORES_ALL      = 4'hf;
  localparam logic [3:0]  CORE_ONE       = 4'h1;
endpackage

// ===== core/pin_sync_edge.sv
// Two-stage pin synchroniser with edge detection on the synchronised level.
`timescale 1ns/1ns
module pin_sync_edge (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;
  logic prev_r;
  logic prev_nxt;

  always_comb begin
    meta_nxt = i_pin;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign o_level = sync_r;
  assign o_rise  = sync_r & ~prev_r;
  assign o_fall  = ~sync_r & prev_r;
endmodule // pin_sync_edge

// ===== tb/pll_cfg_asserts.sv
// Concurrent checks on the ports of the serial configuration port.
`timescale 1ns/1ns
module pll_cfg_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_load_strobe,
  input wire logic        i_cal_done,
  input wire logic [12:0] o_ref_divider,
  input wire logic        o_osc_slope_negative,
  input wire logic [4:0]  o_pump_current_code,
  input wire logic [3:0]  o_cal_clk_scale,
  input wire logic [2:0]  o_cal_clk_div_shift,
  input wire logic [2:0]  o_cal_clk_mul_shift,
  input wire logic [15:0] o_feedback_int_divider,
  input wire logic [2:0]  o_pre_div_ratio,
  input wire logic        o_dual_modulus_select,
  input wire logic [1:0]  o_osc_core_select,
  input wire logic        o_single_core_tune,
  input wire logic [3:0]  o_cal_core_mask,
  input wire logic        o_cal_start,
  input wire logic        o_cal_pending
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_reset_vals: assert property (disable iff (1'b0) i_rst |=>
    o_ref_divider == 13'h0001 && o_osc_slope_negative && o_pump_current_code == 5'h0a
    && o_cal_clk_scale == 4'h8 && o_feedback_int_divider == 16'h0080 && o_dual_modulus_select
    && o_osc_core_select == 2'h2 && !o_cal_start)
    else $error("reset values wrong");
  a_hold_fields: assert property (!i_load_strobe [*6] |=>
    $stable(o_ref_divider) && $stable(o_feedback_int_divider)) else $error("field changed without strobe");
  a_div_shift: assert property (o_cal_clk_scale >= 4'h8 |->
    o_cal_clk_div_shift == o_cal_clk_scale[2:0] && o_cal_clk_mul_shift == 3'h0) else $error("divide shift wrong");
  a_mul_shift: assert property (o_cal_clk_scale <= 4'h6 |->
    o_cal_clk_mul_shift == 3'h7 - o_cal_clk_scale[2:0] && o_cal_clk_div_shift == 3'h0)
    else $error("multiply shift wrong");
  a_pre_ratio: assert property (o_pre_div_ratio inside {3'h1, 3'h2, 3'h4})
    else $error("pre divider ratio illegal");
  a_core_mask: assert property (o_cal_core_mask ==
    (o_single_core_tune ? 4'h1 << o_osc_core_select : 4'hf)) else $error("core mask wrong");
  a_start_pulse: assert property (o_cal_start |=> !o_cal_start) else $error("start longer than one cycle");
  a_start_pend: assert property (o_cal_start |-> o_cal_pending) else $error("start without pending");
  a_pend_rise: assert property ($rose(o_cal_pending) |-> o_cal_start) else $error("pending rose without start");
  a_done_clear: assert property (i_cal_done |=> o_cal_pending == o_cal_start)
    else $error("pending not cleared by done");
endmodule // pll_cfg_asserts

// ===== tb/pll_cfg_host.sv
// Host controller model that shifts words into the configuration port and reads them back.
`timescale 1ns/1ns
module pll_cfg_host (
  input  wire logic i_clk_sys,
  output logic      o_ser_clk,
  output logic      o_ser_data,
  output logic      o_load_strobe,
  input  wire logic i_readback_out
);
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_load_strobe = 1'b0;
  end
  // Shifts 32 bits bit 0 first, samples readback at each rise, then optionally commits with one strobe.
  task automatic xfer(input logic [31:0] word, input logic commit, output logic [31:0] rb);
    @(negedge i_clk_sys);
    #2;
    for (int k = 0; k < 32; k++) begin
      o_ser_data = word[k];
      #62 o_ser_clk = 1'b1;
      rb[k] = i_readback_out;
      #63 o_ser_clk = 1'b0;
    end
    o_ser_data = ~o_ser_data;
    if (commit) begin
      #62 o_load_strobe = 1'b1;
      #63 o_load_strobe = 1'b0;
    end
    #100;
  endtask
endmodule // pll_cfg_host

// ===== tb/tb_pll_serial_config_port.sv
// Self-checking bench for the serial configuration port with its host model and checker.
`timescale 1ns/1ns
module tb_pll_serial_config_port;
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_cal_done = 1'b0;
  logic        i_ser_clk, i_ser_data, i_load_strobe, o_readback_out, o_ref_edge_select, o_osc_slope_negative;
  logic        o_pump_current_x2, o_dual_modulus_select, o_single_core_tune, o_cal_start, o_cal_pending;
  logic [12:0] o_ref_divider;
  logic [4:0]  o_pump_current_code;
  logic [3:0]  o_cal_clk_scale, o_cal_core_mask;
  logic [2:0]  o_cal_clk_div_shift, o_cal_clk_mul_shift, o_pre_div_ratio;
  logic [15:0] o_feedback_int_divider;
  logic [1:0]  o_osc_core_select, o_tune_error_count;
  logic [31:0] r1, r2, rb, seed;
  int          error_cnt = 0, n_checks = 0, cycles = 0, starts = 0;

  pll_serial_config_port pll_serial_config_port_i (.*);
  pll_cfg_host pll_cfg_host_i (.i_clk_sys(i_clk_sys), .o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data),
    .o_load_strobe(i_load_strobe), .i_readback_out(o_readback_out));

  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (o_cal_start === 1'b1) starts <= starts + 1;
    if (cycles == 40000) begin
      error_cnt++;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_fields();
    logic [3:0] s;
    s = r1[30:27];
    chk("ref_div", o_ref_divider, r1[17:5]);
    chk("ref_edge", o_ref_edge_select, r1[19]);
    chk("slope", o_osc_slope_negative, r1[20]);
    chk("pump", o_pump_current_code, r1[25:21]);
    chk("pump_x2", o_pump_current_x2, r1[26]);
    chk("scale", o_cal_clk_scale, s);
    chk("div_shift", o_cal_clk_div_shift, s >= 4'h8 ? s - 4'h8 : 4'h0);
    chk("mul_shift", o_cal_clk_mul_shift, s <= 4'h6 ? 4'h7 - s : 4'h0);
    chk("fb_div", o_feedback_int_divider, r2[20:5]);
    chk("pre_div", o_pre_div_ratio, r2[22:21] == 2'h1 ? 3'h2 : r2[22:21] == 2'h2 ? 3'h4 : 3'h1);
    chk("modulus", o_dual_modulus_select, r2[23]);
    chk("core", o_osc_core_select, r2[27:26]);
    chk("single", o_single_core_tune, r2[28]);
    chk("mask", o_cal_core_mask, r2[28] ? 4'h1 << r2[27:26] : 4'hf);
    chk("err_cnt", o_tune_error_count, r2[30:29]);
    chk("pending", o_cal_pending, r2[31]);
  endtask

  task automatic wr(input logic [31:0] w);
    logic [31:0] dummy;
    pll_cfg_host_i.xfer(w, 1'b1, dummy);
    if (w[4:0] == pll_cfg_pkg::ADDR_REF_PUMP) r1 = w;
    if (w[4:0] == pll_cfg_pkg::ADDR_FB_TUNE) r2 = w;
  endtask

  task automatic rd(input logic [1:0] sel);
    wr({25'h0, sel, 5'h00});
    pll_cfg_host_i.xfer(32'h0, 1'b0, rb);
    chk("readback", rb, sel == 2'h1 ? r1 : r2);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    seed = 32'h00014ece;
    r1 = pll_cfg_pkg::RST_REF_PUMP;
    r2 = pll_cfg_pkg::RST_FB_TUNE;
    repeat (20) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk_fields();
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      wr((rnd() & 32'h07fbffe0) | (i << 27) | 32'h09);
      wr((rnd() & 32'h7c9fffe0) | ((i % 4) << 21) | 32'h0a);
      chk_fields();
    end
    $display("test field decode done");
    rd(2'h1);
    rd(2'h2);
    $display("test readback done");
    wr(rnd() & 32'hffffffe0 | 32'h0b);
    wr(rnd() | 32'h1f);
    chk_fields();
    $display("test unmapped address done");
    wr(r2 | 32'h80000000);
    chk_fields();
    chk("start_cnt", starts, 1);
    @(negedge i_clk_sys);
    i_cal_done = 1'b1;
    @(negedge i_clk_sys);
    i_cal_done = 1'b0;
    r2[31] = 1'b0;
    @(negedge i_clk_sys);
    chk_fields();
    rd(2'h2);
    wr(r2 | 32'h80000000);
    wr(r2 & 32'h7fffffff);
    chk_fields();
    chk("start_cnt", starts, 2);
    $display("test calibration done");
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    r1 = pll_cfg_pkg::RST_REF_PUMP;
    r2 = pll_cfg_pkg::RST_FB_TUNE;
    chk_fields();
    chk("readback_pin", o_readback_out, 1'b0);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule // tb_pll_serial_config_port

bind pll_serial_config_port pll_cfg_asserts pll_cfg_asserts_i (.*);
